// File: dv/serial_register_port_tb.sv
/*
  Testbench of the serial register port: host and device joined by
  a link, plus a second device driven directly for broken frames.
  Assumes the designer's host divider makes the first link clock.
*/
`include "srp_defs.svh"

module serial_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               ref_clk, rst_b, start, rdNotWr, done, portSel, busy;
  logic [7:0]         addr, wdata, rdData, cfgAddr, cfgData, cfg2;
  logic [7:0]         wrAddr, wrData, r2;
  logic [1:0]         style;
  logic               serialActive, wrPulse, drop1, drop2;
  srp_pkg::srp_mode_t busMode;
  int                 err_count, tests_run, wrCnt, dropCnt, cyc;
  int                 mdl [256];
  logic [31:0]        seed;

  srp_link_if lnk ();
  srp_link_if lnk2 ();

  srp_host srp_host_i (.ref_clk, .rst_b, .lnk(lnk), .start, .rdNotWr,
    .addr, .wdata, .busy, .done, .rdData);
  srp_device srp_device_i (.ref_clk, .rst_b, .lnk(lnk),
    .hostPortSelect(portSel), .hostBusStyleSel(style), .busMode,
    .serialActive, .wrPulse, .wrAddr, .wrData, .frameDrop(drop1),
    .cfgAddr, .cfgData);
  srp_device srp_device_i2 (.ref_clk, .rst_b, .lnk(lnk2),
    .hostPortSelect(portSel), .hostBusStyleSel(style), .busMode(),
    .serialActive(), .wrPulse(), .wrAddr(), .wrData(),
    .frameDrop(drop2), .cfgAddr, .cfgData(cfg2));
  srp_link_monitor srp_link_monitor_i (.ref_clk, .rst_b,
    .csB(lnk.csB), .sclk(lnk.sclk), .serial_in_line(lnk.serial_in_line),
    .sdoOut(lnk.sdoOut), .sdoOeB(lnk.sdoOeB), .sdoLine(lnk.sdoLine));

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one host transfer; the model decides what must be seen
  task automatic op(input logic rw, input logic [7:0] a,
                    input logic [7:0] d);
    int n;
    int w0;
    w0 = wrCnt;
    n = 0;
    @(posedge ref_clk);
    #1;
    start = 1'b1;
    rdNotWr = rw;
    addr = a;
    wdata = d;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // a transfer that never finishes counts as a mismatch
    chk("done", 8'h01, {7'h00, done});
    chk("busyEnd", 8'h00, {7'h00, busy});
    if (rw) chk("rdData", portSel ? 8'(mdl[a]) : 8'hFF, rdData);
    else if (portSel) mdl[a] = d;
    repeat (8) @(posedge ref_clk);
    #1;
    chk("wrCnt", 8'(w0 + (!rw && portSel)), 8'(wrCnt));
    if (!rw && portSel) begin
      chk("wrAddr", a, wrAddr);
      chk("wrData", d, wrData);
    end
    cfgAddr = a;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("cfgData", 8'(mdl[a]), cfgData);
  endtask

  // bench-made link clock at 125 ns for the second device
  task automatic frame2(input logic [23:0] b, input int n,
                        output logic [7:0] r);
    r = 8'h00;
    lnk2.sclk = 1'b1;
    #62.5;
    lnk2.sclk = 1'b0;
    #62.5;
    lnk2.csB = 1'b0;
    for (int i = 0; i < n; i++) begin
      lnk2.serial_in_line = b[i];
      #31.25;
      lnk2.sclk = 1'b1;
      #62.5;
      lnk2.sclk = 1'b0;
      #31.25;
      if (i >= 16) r[i-16] = lnk2.sdoLine;
    end
    lnk2.csB = 1'b1;
    #2000;
    // back onto the reference clock so the view is read settled
    @(posedge ref_clk);
    #1;
    cfgAddr = 8'h33;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // -------------------------------------------------------------
  // clock, counters, hang guard
  // -------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the guard is far above the roughly six thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (wrPulse === 1'b1) wrCnt++;
    if (drop1 === 1'b1 || drop2 === 1'b1) dropCnt++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    // a clean fall after time zero reaches every async reset,
    // including the link-side flops that see no reference clock
    rst_b = 1'b1;
    #1;
    rst_b = 1'b0;
    {start, rdNotWr, addr, wdata, cfgAddr} = '0;
    {portSel, style} = '0;
    lnk2.csB = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.serial_in_line = 1'b0;
    seed = 32'h0001_3B79; // starts at 80761
    foreach (mdl[i]) mdl[i] = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    for (int s = 0; s < 4; s++) begin
      style = 2'(s);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("busMode", 8'(s), {6'h00, busMode});
    end
    chk("serialActive", 8'h00, {7'h00, serialActive});
    op(1'b0, 8'h5A, 8'hC3);
    op(1'b1, 8'h5A, 8'h00);
    portSel = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("serialActive", 8'h01, {7'h00, serialActive});
    op(1'b0, 8'h00, 8'hFF);
    op(1'b0, 8'hFF, 8'h01);
    op(1'b1, 8'h00, 8'h00);
    op(1'b1, 8'hFF, 8'h00);
    for (int k = 0; k < 10; k++) begin
      seed = lfsr_next(seed);
      op(seed[9], {seed[7] ? 5'h1F : 5'h00, seed[2:0]}, seed[23:16]);
    end
    rst_b = 1'b0;
    repeat (`SRP_RESET_MIN_CYC + 1) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (5) @(posedge ref_clk);
    op(1'b1, 8'hFF, 8'h00);
    frame2({8'h77, 7'h7F, 1'b0, 8'h33}, 23, r2);
    chk("dropCnt", 8'h01, 8'(dropCnt));
    chk("cfg2", 8'h00, cfg2);
    frame2({8'h77, 7'h7F, 1'b0, 8'h33}, 24, r2);
    chk("cfg2", 8'h77, cfg2);
    frame2({8'h00, 7'h7F, 1'b1, 8'h33}, 24, r2);
    chk("rd2", 8'h77, r2);
    chk("sdo2", 8'h01, {7'h00, lnk2.sdoLine});
    chk("dropCnt", 8'h01, 8'(dropCnt));
    stop_test();
  end
endmodule // serial_register_port_tb

// File: dv/srp_link_monitor.sv
/*
  Link checker for the serial register port: watches the four-wire
  link between host and device ends.
  Assumes it sits beside the interface that joins the two ends.
*/
module srp_link_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic csB,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic sdoOut,
  input wire logic sdoOeB,
  input wire logic sdoLine
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic       sclkD_r;
  logic [4:0] riseCnt_r;
  logic       rwBit_r;
  logic       pre_r;
  logic       rise;

  assign rise = sclk & ~sclkD_r & ~csB;

  // -------------------------------------------------------------
  // helper: frame bit count, direction bit, pre-frame pulse
  // -------------------------------------------------------------
  // count cleared while deselected so each frame starts at zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkD_r   <= 1'b0;
      riseCnt_r <= 5'h00;
      rwBit_r   <= 1'b0;
      pre_r     <= 1'b0;
    end else begin
      sclkD_r   <= sclk;
      riseCnt_r <= csB ? 5'h00 : riseCnt_r + {4'h0, rise};
      if (rise && riseCnt_r == 5'h08) rwBit_r <= serial_in_line;
      pre_r     <= csB ? (pre_r | sclk) : 1'b0;
    end
  end

  // -------------------------------------------------------------
  // link properties
  // -------------------------------------------------------------
  property p_release;
    csB |-> sdoOeB && sdoLine;
  endproperty
  a_release: assert property (p_release)
    else $error("output driven while deselected");
  property p_pre;
    $fell(csB) |-> pre_r;
  endproperty
  a_pre: assert property (p_pre)
    else $error("frame began without a pulse");
  property p_count;
    $rose(csB) |-> riseCnt_r == 5'h18;
  endproperty
  a_count: assert property (p_count)
    else $error("frame bit count wrong");
  property p_hold;
    $rose(sclk) |-> $stable(serial_in_line) ##1 $stable(serial_in_line);
  endproperty
  a_hold: assert property (p_hold)
    else $error("serial input moved at rising edge");
  property p_dummy;
    rise && riseCnt_r >= 5'h09 && riseCnt_r <= 5'h0F |-> !serial_in_line;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy bit not zero");
  property p_rdonly;
    !sdoOeB |-> rwBit_r;
  endproperty
  a_rdonly: assert property (p_rdonly)
    else $error("output driven in a write frame");
  property p_start;
    $fell(sdoOeB) |-> $fell(sclk) && riseCnt_r == 5'h11;
  endproperty
  a_start: assert property (p_start)
    else $error("read output began at wrong edge");
  property p_drive;
    $fell(sdoOeB) |-> !sdoOeB [*8];
  endproperty
  a_drive: assert property (p_drive)
    else $error("read output released early");
  property p_change;
    !sdoOeB && $changed(sdoOut) |-> $fell(sclk);
  endproperty
  a_change: assert property (p_change)
    else $error("read output moved off falling edge");
endmodule // srp_link_monitor

// File: verilog/srp_defs.svh
/*
  Shared constants of the serial register port: frame layout, reset
  values and timing counts.
  Assumes a 100 MHz reference clock and a host-made shift clock.
*/
// Notes on behaviour
// - parallel port default; serial only while strap high
// - reset low over 10 us restores defaults
// - host shifts exactly 24 bits per transaction
// - device samples serial input on rising edge
// - no register update before all 24 bits
// - one clock pulse with select high first
// - read output changes only on falling edges
// - host sends every field least significant first
// - bits 1 to 8 are address, LSB first
// - bit 9: zero writes, one reads
// - bits 10 to 16 are ignored dummies
// - bits 17 to 24 data, stored at select rise
// - read data out on clocks 17 to 24
// - output released when select returns high
// - two-bit select picks the parallel bus style
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define SRP_FRAME_BITS   5'h18
`define SRP_ADDR_BITS    5'h08
`define SRP_RW_POS       5'h08
`define SRP_DATA_POS     5'h10
`define SRP_RD_FIRST     5'h11
`define SRP_RD_LAST      5'h18
`define SRP_REG_COUNT    256
`define SRP_REG_RESET    8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SRP_REF_PERIOD_NS 10
`define SRP_RESET_MIN_NS  10000
`define SRP_RESET_MIN_CYC \
  ((`SRP_RESET_MIN_NS + `SRP_REF_PERIOD_NS - 1) / `SRP_REF_PERIOD_NS)
`define SRP_SCLK_HALF     4

`endif

// File: verilog/srp_device.sv
/*
  Device end of the serial register port: frame capture on the
  shift clock, register file on the reference clock.
  Assumes the host makes the shift clock and holds frame fields
  stable around rising edges.
*/
`include "srp_defs.svh"

module srp_device #(
  parameter int REG_COUNT = `SRP_REG_COUNT
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  srp_link_if.dev                lnk,
  input  wire logic              hostPortSelect,
  input  wire logic [1:0]        hostBusStyleSel,
  output srp_pkg::srp_mode_t     busMode,
  output logic                   serialActive,
  output logic                   wrPulse,
  output logic [7:0]             wrAddr,
  output logic [7:0]             wrData,
  output logic                   frameDrop,
  input  wire logic [7:0]        cfgAddr,
  output logic [7:0]             cfgData
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] regFile [REG_COUNT];
  logic [4:0] bitCnt_r;
  logic [7:0] addr_r;
  logic       rdNotWr_r;
  logic [7:0] data_r;
  logic       frameTgl_r;
  logic       selL1_r;
  logic       selL2_r;
  logic       csS1_r;
  logic       csS2_r;
  logic       csS3_r;
  logic       tglS1_r;
  logic       tglS2_r;
  logic       tglSeen_r;
  logic       selS1_r;
  logic       selS2_r;
  logic [1:0] styleS1_r;
  logic [1:0] styleS2_r;
  logic       csRise;
  logic       newFrame;

  // ---------------------------------------------------------------
  // link domain: shift clock
  // ---------------------------------------------------------------

  // strap into the link domain; it is static, so the sync only
  // guards against metastability at power-up
  always_ff @(posedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      selL1_r <= 1'b0;
      selL2_r <= 1'b0;
    end else begin
      selL1_r <= hostPortSelect;
      selL2_r <= selL1_r;
    end
  end

  // bit counter, cleared while select is high; saturates at 24 so
  // extra clocks cannot wrap into a second frame
  always_ff @(posedge lnk.sclk or posedge lnk.csB or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_r <= 5'h00;
    end else if (lnk.csB) begin
      bitCnt_r <= 5'h00;
    end else if (bitCnt_r != `SRP_FRAME_BITS) begin
      bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // field capture on rising edges, each bit to its own place;
  // fields stay put after select rises for the crossing below;
  // not gated by the link-side strap copy, which needs two shift
  // clocks to settle and would lose the first address bit; the
  // commit side gates on the strap instead
  always_ff @(posedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r    <= 8'h00;
      rdNotWr_r <= 1'b0;
      data_r    <= 8'h00;
    end else if (!lnk.csB) begin
      if (bitCnt_r < `SRP_ADDR_BITS) begin
        addr_r[bitCnt_r[2:0]] <= lnk.serial_in_line;
      end else if (bitCnt_r == `SRP_RW_POS) begin
        rdNotWr_r <= lnk.serial_in_line;
      end else if (bitCnt_r >= `SRP_DATA_POS &&
                   bitCnt_r <  `SRP_FRAME_BITS) begin
        data_r[bitCnt_r[2:0]] <= lnk.serial_in_line;
      end
      // bits 10 to 16 fall through untouched
    end
  end

  // one toggle per complete frame while selL2_r is high; a short frame never toggles
  always_ff @(posedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      frameTgl_r <= 1'b0;
    end else if (!lnk.csB && selL2_r &&
                 bitCnt_r == `SRP_FRAME_BITS - 5'h01) begin
      frameTgl_r <= ~frameTgl_r;
    end
  end

  // read data on falling edges after clocks 17..24; the register
  // file is read across domains, which is safe because it only
  // changes after a write frame has ended
  always_ff @(negedge lnk.sclk or posedge lnk.csB
              or negedge rst_b) begin
    if (!rst_b) begin
      lnk.sdoOeB <= 1'b1;
      lnk.sdoOut <= 1'b0;
    end else if (lnk.csB) begin
      lnk.sdoOeB <= 1'b1;
      lnk.sdoOut <= 1'b0;
    end else if (selL2_r && rdNotWr_r &&
                 bitCnt_r >= `SRP_RD_FIRST &&
                 bitCnt_r <= `SRP_RD_LAST) begin
      lnk.sdoOeB <= 1'b0;
      lnk.sdoOut <= regFile[addr_r][bitCnt_r[2:0] - 3'h1];
    end
  end

  // ---------------------------------------------------------------
  // reference domain: synchronisers
  // ---------------------------------------------------------------

  // select and frame toggle; csS3 only feeds the edge detector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      csS1_r  <= 1'b1;
      csS2_r  <= 1'b1;
      csS3_r  <= 1'b1;
      tglS1_r <= 1'b0;
      tglS2_r <= 1'b0;
    end else begin
      csS1_r  <= lnk.csB;
      csS2_r  <= csS1_r;
      csS3_r  <= csS2_r;
      tglS1_r <= frameTgl_r;
      tglS2_r <= tglS1_r;
    end
  end

  // straps: port select and bus style, caught after release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      selS1_r   <= 1'b0;
      selS2_r   <= 1'b0;
      styleS1_r <= 2'h0;
      styleS2_r <= 2'h0;
    end else begin
      selS1_r   <= hostPortSelect;
      selS2_r   <= selS1_r;
      styleS1_r <= hostBusStyleSel;
      styleS2_r <= styleS1_r;
    end
  end

  assign csRise   = csS2_r & ~csS3_r;
  assign newFrame = tglS2_r ^ tglSeen_r;

  // ---------------------------------------------------------------
  // reference domain: commit and register file
  // ---------------------------------------------------------------

  // a select rise commits only a write frame that completed since the
  // last rise; with the strap high, a rise with no completed frame is dropped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tglSeen_r <= 1'b0;
      wrPulse   <= 1'b0;
      wrAddr    <= 8'h00;
      wrData    <= 8'h00;
      frameDrop <= 1'b0;
    end else begin
      wrPulse   <= 1'b0;
      frameDrop <= 1'b0;
      if (csRise) begin
        tglSeen_r <= tglS2_r;
        if (newFrame && !rdNotWr_r && selS2_r) begin
          wrPulse <= 1'b1;
          wrAddr  <= addr_r;
          wrData  <= data_r;
        end else if (!newFrame && selS2_r) begin
          frameDrop <= 1'b1;
        end
      end
    end
  end

  // register storage; async reset returns every entry to default
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile[i] <= `SRP_REG_RESET;
      end
    end else if (csRise && newFrame && !rdNotWr_r && selS2_r) begin
      regFile[addr_r] <= data_r;
    end
  end

  // local view of one register for the user side
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgData <= `SRP_REG_RESET;
    end else begin
      cfgData <= regFile[cfgAddr];
    end
  end

  // ---------------------------------------------------------------
  // port mode outputs
  // ---------------------------------------------------------------

  // the unused style code is reported as is; the parallel port
  // itself lives elsewhere and decides what to do with it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busMode      <= srp_pkg::SRP_MODE_ASYNC_RDWR;
      serialActive <= 1'b0;
    end else begin
      busMode      <= srp_pkg::srp_mode_t'(styleS2_r);
      serialActive <= selS2_r;
    end
  end

endmodule // srp_device

// File: verilog/srp_host.sv
/*
  Host end of the serial register port: sends one 24-bit frame per
  request and returns read data.
  Assumes the device samples on rising edges and answers on
  falling edges; the shift clock is divided from ref_clk.
*/
`include "srp_defs.svh"

module srp_host #(
  parameter int HALF = `SRP_SCLK_HALF
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  srp_link_if.host        lnk,
  input  wire logic       start,
  input  wire logic       rdNotWr,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdData
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  srp_pkg::srp_host_st_t state_r;
  logic [3:0]  cnt_r;
  logic        tick;
  logic [4:0]  bitIdx_r;
  logic [23:0] frame_r;
  logic [7:0]  rdSh_r;
  logic        sdoS1_r;
  logic        sdoS2_r;

  // ---------------------------------------------------------------
  // clock divider and input sync
  // ---------------------------------------------------------------

  // half-period counter, held while idle so frames start aligned
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (tick || state_r == srp_pkg::SRP_ST_IDLE) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign tick = (cnt_r == 4'(HALF - 1));
  assign busy = (state_r != srp_pkg::SRP_ST_IDLE);

  // serial output comes from another domain
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdoS1_r <= 1'b1;
      sdoS2_r <= 1'b1;
    end else begin
      sdoS1_r <= lnk.sdoLine;
      sdoS2_r <= sdoS1_r;
    end
  end

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------

  // data changes with the falling edge, read bits are taken just
  // before the next rising edge when the sync has settled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= srp_pkg::SRP_ST_IDLE;
      lnk.sclk <= 1'b0;
      lnk.csB  <= 1'b1;
      lnk.serial_in_line  <= 1'b0;
      bitIdx_r <= 5'h00;
      frame_r  <= 24'h00_0000;
      rdSh_r   <= 8'h00;
      rdData   <= 8'h00;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        srp_pkg::SRP_ST_IDLE: begin
          if (start) begin
            frame_r <= {wdata, 7'h00, rdNotWr, addr};
            state_r <= srp_pkg::SRP_ST_PRE;
          end
        end
        srp_pkg::SRP_ST_PRE: begin
          if (tick) begin
            if (!lnk.sclk) begin
              lnk.sclk <= 1'b1;
            end else begin
              lnk.sclk <= 1'b0;
              lnk.csB  <= 1'b0;
              lnk.serial_in_line  <= frame_r[0];
              bitIdx_r <= 5'h00;
              state_r  <= srp_pkg::SRP_ST_SHIFT;
            end
          end
        end
        srp_pkg::SRP_ST_SHIFT: begin
          if (tick) begin
            if (!lnk.sclk) begin
              lnk.sclk <= 1'b1;
              if (bitIdx_r >= `SRP_RD_FIRST) begin
                rdSh_r <= {sdoS2_r, rdSh_r[7:1]};
              end
            end else begin
              lnk.sclk <= 1'b0;
              if (bitIdx_r == `SRP_FRAME_BITS - 5'h01) begin
                state_r <= srp_pkg::SRP_ST_TAIL;
              end else begin
                bitIdx_r <= bitIdx_r + 5'h01;
                lnk.serial_in_line  <= frame_r[bitIdx_r + 5'h01];
              end
            end
          end
        end
        srp_pkg::SRP_ST_TAIL: begin
          if (tick) begin
            rdData  <= {sdoS2_r, rdSh_r[7:1]};
            lnk.csB <= 1'b1;
            state_r <= srp_pkg::SRP_ST_GAP;
          end
        end
        srp_pkg::SRP_ST_GAP: begin
          if (tick) begin
            done    <= 1'b1;
            state_r <= srp_pkg::SRP_ST_IDLE;
          end
        end
        default: begin
          state_r <= srp_pkg::SRP_ST_IDLE;
        end
      endcase
    end
  end

endmodule // srp_host

// File: verilog/srp_link_if.sv
/*
  Four-wire link between host and device.
  Assumes an idle serial output reads high (pull-up on the wire).
*/
interface srp_link_if;
  logic csB;
  logic sclk;
  logic serial_in_line;
  logic sdoOut;
  logic sdoOeB;
  logic sdoLine;

  // released line is pulled high
  assign sdoLine = sdoOeB ? 1'b1 : sdoOut;

  modport dev (
    input  csB,
    input  sclk,
    input  serial_in_line,
    output sdoOut,
    output sdoOeB
  );

  modport host (
    output csB,
    output sclk,
    output serial_in_line,
    input  sdoLine
  );
endinterface

// File: verilog/srp_pkg.sv
/*
  Types of the serial register port.
  Assumes nothing beyond the constants header.
*/
package srp_pkg;

  // parallel bus style chosen by the two-bit select
  typedef enum logic [1:0] {
    SRP_MODE_ASYNC_RDWR = 2'h0,
    SRP_MODE_ASYNC_DS   = 2'h1,
    SRP_MODE_UNUSED     = 2'h2,
    SRP_MODE_SYNC       = 2'h3
  } srp_mode_t;

  // host frame sequencer
  typedef enum logic [2:0] {
    SRP_ST_IDLE  = 3'b000,
    SRP_ST_PRE   = 3'b001,
    SRP_ST_SHIFT = 3'b010,
    SRP_ST_TAIL  = 3'b011,
    SRP_ST_GAP   = 3'b100
  } srp_host_st_t;

endpackage
